// File: icache_tag_map.vh
// Constants for the instruction cache tag store.
// Included by icache_tag_ram_compare.v; definitions only.
`ifndef ICACHE_TAG_MAP_VH
`define ICACHE_TAG_MAP_VH

`define ITAG_ENTRIES 1024
`define ITAG_ADDR_W 10
`define ITAG_TAG_W 18
`define ITAG_ENTRY_W 19
`define ITAG_VALID_BIT 0
`define ITAG_TAG_LSB 1
`define ITAG_TAG_MSB 18
`define ITAG_FETCH_IDX_MSB 13
`define ITAG_FETCH_IDX_LSB 4
`define ITAG_LINE_WORDS 4
`define ITAG_RST_TAG 18'h00000
`define ITAG_RST_VLD 1'h0
`define ITAG_RST_ADDR 10'h000
`define ITAG_RST_CTL 1'h0
`define ITAG_RST_HIT 1'h0

`endif

// File: icache_tag_ram_compare.v
// Instruction cache tag store with built-in 19-bit hit compare.
// One line of four instruction words per entry; writes never move the outputs.
// Assumes one clock; inputs come from logic on that clock, so no synchronisers.
// Array has no reset; an entry reads unknown until first written.
`timescale 1ns/1ps
`include "icache_tag_map.vh"

// Notes on behaviour
// - 1,024 entries of 19 bits each.
// - One entry per four-word cache line.
// - Normal inputs: 10-bit index, 18-bit tag, valid.
// - Valid in bit 0, separate valid output.
// - Hit when stored entry equals {tag, 1}.
// - Enabled, test mode 1 selects self-test inputs.
// - Enabled, test mode 0 selects normal inputs.
// - Enable low: no reads, no writes.
// - Disabled: tag, valid, hit outputs hold.
// - All inputs registered; no input-to-output path.
// - Index is fetch address bits 13:4.
// - Write enable writes entry, else reads.
module icache_tag_ram_compare (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Control
    input wire enable_i,
    input wire test_mode_i,
    // Normal port from cache controller
    input wire [`ITAG_ADDR_W-1:0] tag_addr_i,
    input wire [`ITAG_TAG_W-1:0] tag_in_i,
    input wire tag_vld_i,
    input wire tag_we_i,
    // Self-test port
    input wire [`ITAG_ADDR_W-1:0] bist_tag_addr_i,
    input wire [`ITAG_TAG_W-1:0] bist_tag_in_i,
    input wire bist_tag_vld_i,
    input wire bist_tag_we_i,
    // Results
    output wire [`ITAG_TAG_W-1:0] tag_dout_o,
    output wire tag_vld_o,
    output wire tag_hit_o
);

    // Entry storage, tag above valid
    reg [`ITAG_ENTRY_W-1:0] mem [0:`ITAG_ENTRIES-1];

    // Boundary registers, control
    reg en_q;
    reg tm_q;

    // Boundary registers, normal port
    reg [`ITAG_ADDR_W-1:0] addr_q;
    reg [`ITAG_TAG_W-1:0] tag_q;
    reg vld_q;
    reg we_q;

    // Boundary registers, self-test port
    reg [`ITAG_ADDR_W-1:0] baddr_q;
    reg [`ITAG_TAG_W-1:0] btag_q;
    reg bvld_q;
    reg bwe_q;

    // Read results and their next values
    reg [`ITAG_TAG_W-1:0] dout_q;
    reg [`ITAG_TAG_W-1:0] dout_d;
    reg dvld_q;
    reg dvld_d;
    reg hit_q;
    reg hit_d;

    // Selected access
    reg [`ITAG_ADDR_W-1:0] sel_addr;
    reg [`ITAG_TAG_W-1:0] sel_tag;
    reg sel_vld;
    reg sel_we;

    // Access decode
    wire do_write;
    wire do_read;
    wire [`ITAG_ENTRY_W-1:0] wr_entry;

    // Entry read and compare
    wire [`ITAG_ENTRY_W-1:0] rd_entry;
    wire [`ITAG_TAG_W-1:0] rd_tag;
    wire rd_vld;
    wire [`ITAG_ENTRY_W-1:0] ref_entry;
    wire [`ITAG_ENTRY_W-1:0] bit_match;
    wire tag_match;
    wire vld_match;
    wire wide_equality_compare;
    genvar gi;

    // Enable; resets low so the store starts idle
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= `ITAG_RST_CTL;
        end else begin
            en_q <= enable_i;
        end
    end

    // Test-mode select
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tm_q <= `ITAG_RST_CTL;
        end else begin
            tm_q <= test_mode_i;
        end
    end

    // Normal index
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= `ITAG_RST_ADDR;
        end else begin
            addr_q <= tag_addr_i;
        end
    end

    // Normal tag
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_q <= `ITAG_RST_TAG;
        end else begin
            tag_q <= tag_in_i;
        end
    end

    // Normal valid
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vld_q <= `ITAG_RST_VLD;
        end else begin
            vld_q <= tag_vld_i;
        end
    end

    // Normal write enable
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            we_q <= `ITAG_RST_CTL;
        end else begin
            we_q <= tag_we_i;
        end
    end

    // Self-test index
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baddr_q <= `ITAG_RST_ADDR;
        end else begin
            baddr_q <= bist_tag_addr_i;
        end
    end

    // Self-test tag
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            btag_q <= `ITAG_RST_TAG;
        end else begin
            btag_q <= bist_tag_in_i;
        end
    end

    // Self-test valid
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvld_q <= `ITAG_RST_VLD;
        end else begin
            bvld_q <= bist_tag_vld_i;
        end
    end

    // Self-test write enable
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bwe_q <= `ITAG_RST_CTL;
        end else begin
            bwe_q <= bist_tag_we_i;
        end
    end

    // Index by test mode
    always @* begin
        if (tm_q) begin
            sel_addr = baddr_q;
        end else begin
            sel_addr = addr_q;
        end
    end

    // Tag by test mode
    always @* begin
        if (tm_q) begin
            sel_tag = btag_q;
        end else begin
            sel_tag = tag_q;
        end
    end

    // Valid by test mode
    always @* begin
        if (tm_q) begin
            sel_vld = bvld_q;
        end else begin
            sel_vld = vld_q;
        end
    end

    // Write enable by test mode
    always @* begin
        if (tm_q) begin
            sel_we = bwe_q;
        end else begin
            sel_we = we_q;
        end
    end

    // Only an enabled access touches the array
    assign do_write = en_q & sel_we;
    assign do_read = en_q & ~sel_we;

    // Valid goes in bit 0 below the tag
    assign wr_entry = {sel_tag, sel_vld};

    // Array write; contents unknown until written
    always @(posedge ref_clk_i) begin
        if (do_write) begin
            mem[sel_addr] <= wr_entry;
        end
    end

    // Combinational read of the selected entry
    assign rd_entry = mem[sel_addr];
    assign rd_tag = rd_entry[`ITAG_TAG_MSB:`ITAG_TAG_LSB];
    assign rd_vld = rd_entry[`ITAG_VALID_BIT];

    // Stored entry against latched tag with constant one
    assign ref_entry = {sel_tag, 1'h1};

    // Per-bit equality, folded into the 19-bit compare
    generate
        for (gi = 0; gi < `ITAG_ENTRY_W; gi = gi + 1) begin : g_bit_cmp
            assign bit_match[gi] = ~(rd_entry[gi] ^ ref_entry[gi]);
        end
    endgenerate

    assign tag_match = &bit_match[`ITAG_TAG_MSB:`ITAG_TAG_LSB];
    assign vld_match = bit_match[`ITAG_VALID_BIT];
    assign wide_equality_compare = tag_match & vld_match;

    // Stored tag; anything but an enabled read holds it
    always @* begin
        if (do_read) begin
            dout_d = rd_tag;
        end else begin
            dout_d = dout_q;
        end
    end

    // Stored valid; held the same way
    always @* begin
        if (do_read) begin
            dvld_d = rd_vld;
        end else begin
            dvld_d = dvld_q;
        end
    end

    // Hit; held the same way
    always @* begin
        if (do_read) begin
            hit_d = wide_equality_compare;
        end else begin
            hit_d = hit_q;
        end
    end

    // Stored tag register
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_q <= `ITAG_RST_TAG;
        end else begin
            dout_q <= dout_d;
        end
    end

    // Stored valid register
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dvld_q <= `ITAG_RST_VLD;
        end else begin
            dvld_q <= dvld_d;
        end
    end

    // Hit register
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hit_q <= `ITAG_RST_HIT;
        end else begin
            hit_q <= hit_d;
        end
    end

    // Outputs straight from flip-flops
    assign tag_dout_o = dout_q;
    assign tag_vld_o = dvld_q;
    assign tag_hit_o = hit_q;

endmodule

// File: icache_tag_properties.sv
// Output checks for the tag store; bound to its ports, inputs held low in reset.
`timescale 1ns/1ps
module icache_tag_properties (
    input wire ref_clk_i, rst_n_i, enable_i, test_mode_i, tag_vld_i, tag_we_i, bist_tag_vld_i,
    input wire bist_tag_we_i, tag_vld_o, tag_hit_o,
    input wire [9:0] tag_addr_i, bist_tag_addr_i,
    input wire [17:0] tag_in_i, bist_tag_in_i, tag_dout_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Inputs seen at edge N move the outputs at edge N+1, sampled at N+2
    wire rd = enable_i & ~(test_mode_i ? bist_tag_we_i : tag_we_i);
    wire brd = rd & test_mode_i;
    wire nrd = rd & ~test_mode_i;
    wire nwr = enable_i & ~test_mode_i & tag_we_i;
    wire [19:0] o = {tag_dout_o, tag_vld_o, tag_hit_o};
    property p_off; !$past(enable_i, 2) |-> $stable(o); endproperty
    a_off: assert property (p_off) else $error("moved while off");
    property p_wr; $past(enable_i, 2) && !$past(rd, 2) |-> $stable(o); endproperty
    a_wr: assert property (p_wr) else $error("moved on write");
    property p_hit; tag_hit_o |-> tag_vld_o; endproperty
    a_hit: assert property (p_hit) else $error("hit on invalid");
    property p_bist; $past(brd, 2) |-> tag_hit_o == (tag_vld_o && tag_dout_o == $past(bist_tag_in_i, 2));
    endproperty
    a_bist: assert property (p_bist) else $error("test hit wrong");
    property p_norm; $past(nrd, 2) |-> tag_hit_o == (tag_vld_o && tag_dout_o == $past(tag_in_i, 2));
    endproperty
    a_norm: assert property (p_norm) else $error("normal hit wrong");
    property p_raw; $past(nwr, 3) && $past(nrd, 2) && $past(tag_addr_i, 2) == $past(tag_addr_i, 3)
        |-> tag_dout_o == $past(tag_in_i, 3) && tag_vld_o == $past(tag_vld_i, 3);
    endproperty
    a_raw: assert property (p_raw) else $error("read after write stale");
endmodule
bind icache_tag_ram_compare icache_tag_properties i_p (.*);

// File: icache_ctrl_model.sv
// Controller and self-test driver; the idle port always offers a clashing write.
`timescale 1ns/1ps
module icache_ctrl_model (
    input wire ref_clk_i,
    output reg enable_i, test_mode_i, tag_vld_i, tag_we_i, bist_tag_vld_i, bist_tag_we_i,
    output reg [9:0] tag_addr_i, bist_tag_addr_i,
    output reg [17:0] tag_in_i, bist_tag_in_i
);
    initial {enable_i, test_mode_i, tag_vld_i, tag_we_i, bist_tag_vld_i, bist_tag_we_i} = '0;
    initial {tag_addr_i, bist_tag_addr_i, tag_in_i, bist_tag_in_i} = '0;
    task acc(input e, t, w, input [9:0] a, input [17:0] g, input v);
        @(posedge ref_clk_i);
        {enable_i, test_mode_i} <= {e, t};
        {tag_we_i, tag_addr_i, tag_in_i, tag_vld_i} <= t ? {1'b1, a, ~g, ~v} : {w, a, g, v};
        {bist_tag_we_i, bist_tag_addr_i, bist_tag_in_i, bist_tag_vld_i} <= t ? {w, a, g, v} : {1'b1, a, ~g, ~v};
    endtask
endmodule

// File: tb.sv
// Self-checking bench for the tag store; drives it through the controller model.
`timescale 1ns/1ps
module tb;
    reg ref_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    wire enable_i, test_mode_i, tag_vld_i, tag_we_i, bist_tag_vld_i, bist_tag_we_i, tag_vld_o, tag_hit_o;
    wire [9:0] tag_addr_i, bist_tag_addr_i;
    wire [17:0] tag_in_i, bist_tag_in_i, tag_dout_o;
    integer mismatches = 0, num_checks = 0, cyc = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    icache_tag_ram_compare i_icache_tag_ram_compare (.*);
    icache_ctrl_model i_icache_ctrl_model (.*);
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input [19:0] e);
        num_checks++;
        if ({tag_dout_o, tag_vld_o, tag_hit_o} !== e) begin
            mismatches++;
            $display("MISMATCH %0t %h %h", $time, e, {tag_dout_o, tag_vld_o, tag_hit_o});
        end
    endtask
    // Read, then a disabled write to the inverted index while the answer lands
    task rd(input t, input [9:0] a, input [17:0] g, input [19:0] e);
        i_icache_ctrl_model.acc(1, t, 0, a, g, 1);
        i_icache_ctrl_model.acc(0, t, 1, ~a, ~g, 0);
        @(posedge ref_clk_i);
        #1 chk(e);
    endtask
    task t_run;
        i_icache_ctrl_model.acc(1, 0, 1, 10'h3FF, 18'h2AAAA, 1);
        rd(0, 10'h3FF, 18'h2AAAA, {18'h2AAAA, 2'h3});
        rd(0, 10'h3FF, 18'h2AAAB, {18'h2AAAA, 2'h2});
        i_icache_ctrl_model.acc(1, 1, 1, 10'h000, 18'h3FFFF, 0);
        rd(1, 10'h000, 18'h3FFFF, {18'h3FFFF, 2'h0});
        rd(1, 10'h3FF, 18'h2AAAA, {18'h2AAAA, 2'h3});
        i_icache_ctrl_model.acc(0, 0, 1, 10'h3FF, 18'h00000, 0);
        i_icache_ctrl_model.acc(1, 0, 1, 10'h001, 18'h00001, 1);
        rd(0, 10'h3FF, 18'h2AAAA, {18'h2AAAA, 2'h3});
        // Disabled reads of another entry, both modes, must not move the outputs
        i_icache_ctrl_model.acc(0, 1, 0, 10'h000, 18'h3FFFF, 1);
        i_icache_ctrl_model.acc(0, 0, 0, 10'h000, 18'h3FFFF, 1);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({18'h2AAAA, 2'h3});
        $display("t_run end");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_run;
        finish_test;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            mismatches++;
            finish_test;
        end
    end
endmodule
